// ===== hw/priority_interrupt_controller.sv
// Purpose: eight-level programmable priority interrupt controller
// Assumes: host strobes are one-cycle pulses on mclk; request pins async
// Notes: registers sit at the lower and upper host ports only
//
// Functional notes
// - eight request levels, 0 highest and 7 lowest by default.
// - fully nested priority after init unless software rotates.
// - in service blocks equal or lower levels, higher still pass.
// - in-service bit stays until end-of-service command or auto clear.
// - automatic rotation makes the serviced level the lowest.
// - automatic rotation advances at acknowledge in automatic end-of-service mode, or on a rotating end-of-service command.
// - specific rotation: software names bottom, next level becomes top.
// - rotating specific end-of-service clears named level and makes it bottom.
// - bottom level may be set anytime without ending service.
// - each input is maskable only after the third init word; init clears the mask.
// - masked in-service level still blocks lower ones without special mode.
// - special mask mode lets lower levels through until reset.
// - poll read acts as acknowledge and returns highest pending level.
// - keeps pending, in-service and masked sets of eight bits.
// - host selects a set by command word, then reads it back.
// - exactly three init words; normal operation after the third.
// - first-word bit 3 picks level (0) or rising edge (1) requests.
// - vector upper bits from second word, low bits are the level.
// - third-word bit 1 enables automatic end-of-service.
// - non-specific end-of-service clears highest in-service bit.
// - 0ah selects pending read-back, 0bh in-service read-back.
// - mask byte bit n masks input n; upper port read gives mask.
// - 68h sets and 48h resets special mask mode.
`timescale 1ns/1ps
module priority_interrupt_controller
    import pic_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host port
    input wire bus_req_s bus,
    output logic [7:0] rdata,
    output logic rdata_valid,
    // request pins
    input wire logic [7:0] request_input,
    // processor side
    output logic intr,
    input wire logic ack,
    output logic [7:0] vector,
    output logic vector_valid
);
    init_e state, next_state;
    logic [4:0] vector_upper_bits, next_vector_upper_bits;
    logic edge_mode, next_edge_mode;
    logic auto_end_of_service, next_auto_end_of_service;
    logic rot_auto, next_rot_auto;
    logic smm, next_smm;
    logic poll, next_poll;
    logic rb_isr, next_rb_isr;
    logic [7:0] masked_level_set, next_masked_level_set;
    logic [7:0] in_service_set, next_in_service_set;
    logic [7:0] edge_latch, next_edge_latch;
    logic [2:0] bottom, next_bottom;
    logic [7:0] next_rdata;
    logic next_rdata_valid;
    logic next_intr;
    logic [7:0] next_vector;
    logic next_vector_valid;

    logic [7:0] req_level;
    logic [7:0] req_rise;
    logic [7:0] pending_request_set;
    logic [7:0] blocking_set;
    pick_s req_pick, blk_pick, isr_pick;
    logic armed, eligible, ack_evt;
    logic is_lo, is_hi, wr_lo, wr_hi, rd_lo, rd_hi;
    logic [2:0] op;
    logic [2:0] level_code_bits;

    req_sync #(
        .WIDTH(NUM_LEVELS)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din(request_input),
        .level(req_level),
        .rise(req_rise)
    );

    // edge requests stay pending only while the input is still high
    assign pending_request_set = edge_mode ? (edge_latch & req_level)
                                           : req_level;
    // special mask mode lets masked in-service levels stop blocking
    assign blocking_set = smm ? (in_service_set & ~masked_level_set)
                              : in_service_set;

    priority_pick u_req (
        .vec(pending_request_set & ~masked_level_set),
        .bottom(bottom),
        .res(req_pick)
    );

    priority_pick u_blk (
        .vec(blocking_set),
        .bottom(bottom),
        .res(blk_pick)
    );

    priority_pick u_isr (
        .vec(in_service_set),
        .bottom(bottom),
        .res(isr_pick)
    );

    assign armed = (state == st_run);
    // equal rank means same level already in service, so it is held off
    assign eligible = armed && req_pick.found
        && (!blk_pick.found || req_pick.rank < blk_pick.rank);
    assign is_lo = bus.cs && (bus.addr == PORT_LOWER);
    assign is_hi = bus.cs && (bus.addr == PORT_UPPER);
    assign wr_lo = is_lo && bus.wr;
    assign wr_hi = is_hi && bus.wr;
    assign rd_lo = is_lo && bus.rd;
    assign rd_hi = is_hi && bus.rd;
    assign ack_evt = armed && (ack || (rd_lo && poll));
    assign op = bus.wdata[7:5];
    assign level_code_bits = bus.wdata[2:0];

    always_comb
    begin
        logic [7:0] isr_clr;
        logic [7:0] isr_set;
        logic [7:0] edge_clr;
        logic [2:0] taken;
        isr_clr = '0;
        isr_set = '0;
        edge_clr = '0;
        taken = eligible ? req_pick.level : SPURIOUS_LEVEL;
        next_state = state;
        next_vector_upper_bits = vector_upper_bits;
        next_edge_mode = edge_mode;
        next_auto_end_of_service = auto_end_of_service;
        next_rot_auto = rot_auto;
        next_smm = smm;
        next_poll = poll;
        next_rb_isr = rb_isr;
        next_masked_level_set = masked_level_set;
        next_bottom = bottom;
        next_rdata = rdata;
        next_rdata_valid = 1'b0;
        next_vector = vector;
        next_vector_valid = 1'b0;

        // acknowledge, by strobe or by a poll read
        if (ack_evt)
        begin
            if (eligible)
            begin
                edge_clr[taken] = 1'b1;
                if (!auto_end_of_service)
                    isr_set[taken] = 1'b1;
                else if (rot_auto)
                    next_bottom = taken;
            end
            if (!(rd_lo && poll))
            begin
                next_vector = {vector_upper_bits, taken};
                next_vector_valid = 1'b1;
            end
        end

        // host writes to the lower port
        if (wr_lo)
        begin
            if (bus.wdata[FIRST_INIT_BIT])
            begin
                // restarts the init sequence from a known state
                next_state = st_vec;
                next_edge_mode = bus.wdata[EDGE_MODE_BIT];
                next_masked_level_set = MASK_RESET;
                isr_clr = 8'hff;
                edge_clr = 8'hff;
                next_bottom = BOTTOM_RESET;
                next_smm = 1'b0;
                next_poll = 1'b0;
                next_rb_isr = 1'b0;
                next_rot_auto = 1'b0;
                next_auto_end_of_service = 1'b0;
            end
            else if (bus.wdata[READBACK_BIT])
            begin
                if (bus.wdata[RB_ENABLE_BIT])
                    next_rb_isr = bus.wdata[RB_SELECT_BIT];
                next_poll = bus.wdata[POLL_BIT];
                if (bus.wdata[SMM_ENABLE_BIT])
                    next_smm = bus.wdata[SMM_VALUE_BIT];
            end
            else
            begin
                case (op)
                    OP_EOS:
                        isr_clr[isr_pick.level] = isr_pick.found;
                    OP_ROT_EOS:
                    begin
                        isr_clr[isr_pick.level] = isr_pick.found;
                        if (isr_pick.found)
                            next_bottom = isr_pick.level;
                    end
                    OP_SPEC_EOS:
                        isr_clr[level_code_bits] = 1'b1;
                    OP_ROT_SPEC_EOS:
                    begin
                        isr_clr[level_code_bits] = 1'b1;
                        next_bottom = level_code_bits;
                    end
                    OP_SET_BOTTOM:
                        next_bottom = level_code_bits;
                    OP_SET_ROT_AUTO:
                        next_rot_auto = 1'b1;
                    OP_CLR_ROT_AUTO:
                        next_rot_auto = 1'b0;
                    default:
                        next_rot_auto = rot_auto;
                endcase
            end
        end

        // host writes to the upper port
        if (wr_hi)
        begin
            case (state)
                st_vec:
                begin
                    next_vector_upper_bits = bus.wdata[7:VEC_LSB];
                    next_state = st_opt;
                end
                st_opt:
                begin
                    next_auto_end_of_service = bus.wdata[AUTO_EOS_BIT];
                    next_state = st_run;
                end
                st_run:
                    next_masked_level_set = bus.wdata;
                default:
                    next_state = state;
            endcase
        end

        // reads return registered data one cycle later
        if (bus.cs && bus.rd)
        begin
            next_rdata_valid = 1'b1;
            if (rd_lo && poll)
            begin
                next_rdata = {eligible, 4'h0, taken};
                next_poll = 1'b0;
            end
            else if (rd_lo)
                next_rdata = rb_isr ? in_service_set
                                    : pending_request_set;
            else if (rd_hi)
                next_rdata = masked_level_set;
            else
                next_rdata = 8'h00;
        end

        // a new acknowledge outweighs a clear in the same cycle
        next_in_service_set = (in_service_set & ~isr_clr) | isr_set;
        next_edge_latch = (edge_latch & ~edge_clr) | req_rise;
        // drop the request as soon as it is taken
        next_intr = eligible && !ack_evt;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= st_uninit;
            vector_upper_bits <= VECTOR_BASE_RESET;
            edge_mode <= 1'b0;
            auto_end_of_service <= 1'b0;
            rot_auto <= 1'b0;
            smm <= 1'b0;
            poll <= 1'b0;
            rb_isr <= 1'b0;
            masked_level_set <= MASK_RESET;
            in_service_set <= '0;
            edge_latch <= '0;
            bottom <= BOTTOM_RESET;
            rdata <= '0;
            rdata_valid <= 1'b0;
            intr <= 1'b0;
            vector <= '0;
            vector_valid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            vector_upper_bits <= next_vector_upper_bits;
            edge_mode <= next_edge_mode;
            auto_end_of_service <= next_auto_end_of_service;
            rot_auto <= next_rot_auto;
            smm <= next_smm;
            poll <= next_poll;
            rb_isr <= next_rb_isr;
            masked_level_set <= next_masked_level_set;
            in_service_set <= next_in_service_set;
            edge_latch <= next_edge_latch;
            bottom <= next_bottom;
            rdata <= next_rdata;
            rdata_valid <= next_rdata_valid;
            intr <= next_intr;
            vector <= next_vector;
            vector_valid <= next_vector_valid;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_vec_step;
        state == st_vec && wr_hi;
    endsequence

    sequence s_opt_step;
        state == st_opt && wr_hi;
    endsequence

    // the host may leave idle cycles between the init words
    AST_INIT_SEQ: assert property (
        s_vec_step ##[1:8] s_opt_step |=> armed)
        else $error("third init word did not arm the controller");

    AST_FIRST_DISARMS: assert property (
        wr_lo && bus.wdata[FIRST_INIT_BIT] |=> !armed && bottom == 3'h7)
        else $error("first init word did not restart");

    AST_INTR_CAUSE: assert property (
        intr |-> $past(eligible) && !$past(ack_evt))
        else $error("interrupt raised without an eligible request");

    AST_NESTED_BLOCK: assert property (
        req_pick.found && blk_pick.found
        && req_pick.rank >= blk_pick.rank |=> !intr)
        else $error("lower or equal request passed an in-service level");

    AST_ACK_VECTOR: assert property (
        ack && armed && eligible |=> vector_valid
        && vector == {$past(vector_upper_bits), $past(req_pick.level)})
        else $error("vector byte wrong after acknowledge");

    AST_SPEC_CLEAR: assert property (
        wr_lo && bus.wdata[7:3] == 5'h1c && !ack_evt
        |=> !in_service_set[$past(level_code_bits)]
        && bottom == $past(level_code_bits))
        else $error("specific end of service failed");

    AST_SET_BOTTOM: assert property (
        wr_lo && bus.wdata[7:3] == 5'h18 |=> bottom == $past(level_code_bits))
        else $error("bottom level not taken");

    AST_MASK_WR: assert property (
        armed && wr_hi ##1 !wr_hi ##1 rd_hi |=> rdata == $past(bus.wdata, 3))
        else $error("mask read-back differs from write");

    AST_AUTO_EOS: assert property (
        auto_end_of_service && ack && eligible
        |=> in_service_set == $past(in_service_set))
        else $error("automatic end of service left a bit set");

    AST_POLL_READ: assert property (
        rd_lo && poll && eligible |=> rdata_valid && rdata[7]
        && rdata[2:0] == $past(req_pick.level))
        else $error("poll read returned wrong level");
endmodule

// ===== hw/pic_pkg.sv
// Purpose: shared constants and carriers for the priority interrupt block
// Assumes: byte-wide host port on the same clock as the controller
// Notes: port offsets are the byte addresses seen by the host
package pic_pkg;
    localparam logic [7:0] PORT_LOWER = 8'hc0;
    localparam logic [7:0] PORT_UPPER = 8'hc2;
    localparam int NUM_LEVELS = 8;
    // values after reset, and the level given when no request is eligible
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] BOTTOM_RESET = 3'h7;
    localparam logic [4:0] VECTOR_BASE_RESET = 5'h00;
    localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
    // field positions of the lower- and upper-port words
    localparam int FIRST_INIT_BIT = 4;
    localparam int EDGE_MODE_BIT = 3;
    localparam int READBACK_BIT = 3;
    localparam int POLL_BIT = 2;
    localparam int RB_ENABLE_BIT = 1;
    localparam int RB_SELECT_BIT = 0;
    localparam int SMM_ENABLE_BIT = 6;
    localparam int SMM_VALUE_BIT = 5;
    localparam int AUTO_EOS_BIT = 1;
    localparam int VEC_LSB = 3;
    // priority operation codes, bits 7..5
    localparam logic [2:0] OP_CLR_ROT_AUTO = 3'h0;
    localparam logic [2:0] OP_EOS = 3'h1;
    localparam logic [2:0] OP_SPEC_EOS = 3'h3;
    localparam logic [2:0] OP_SET_ROT_AUTO = 3'h4;
    localparam logic [2:0] OP_ROT_EOS = 3'h5;
    localparam logic [2:0] OP_SET_BOTTOM = 3'h6;
    localparam logic [2:0] OP_ROT_SPEC_EOS = 3'h7;

    typedef enum logic [1:0] {st_uninit, st_vec, st_opt, st_run} init_e;

    typedef struct packed {
        logic cs;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic found;
        logic [2:0] level;
        logic [2:0] rank;
    } pick_s;
endpackage

// ===== hw/req_sync.sv
// Purpose: two-stage synchroniser for request pins with rise detection
// Assumes: pins are asynchronous to mclk
// Notes: rise is taken from the second and third stages only
`timescale 1ns/1ps
module req_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pins
    input wire logic [WIDTH-1:0] din,
    // synchronised view
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] prev;

    // refused at elaboration: a zero-width bank has no pins to watch
    if (WIDTH < 1)
    begin
        $error("req_sync: WIDTH must be positive");
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta <= '0;
            stage <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= din;
            stage <= meta;
            prev <= stage;
        end
    end

    assign level = stage;
    assign rise = stage & ~prev;
endmodule

// ===== hw/priority_pick.sv
// Purpose: find the highest-ranked set bit under a rotating priority
// Assumes: the level just above bottom ranks first, circularly
// Notes: rank 0 is highest; purely combinational
`timescale 1ns/1ps
module priority_pick
    import pic_pkg::*;
(
    // candidates and rotation
    input wire logic [7:0] vec,
    input wire logic [2:0] bottom,
    // winner
    output pick_s res
);
    always_comb
    begin
        logic [2:0] lvl;
        lvl = '0;
        res = '0;
        // scan from lowest rank upward so the top rank is kept last
        for (int i = NUM_LEVELS - 1; i >= 0; i--)
        begin
            lvl = 3'(bottom + 3'h1 + i[2:0]);
            if (vec[lvl])
            begin
                res.found = 1'b1;
                res.level = lvl;
                res.rank = i[2:0];
            end
        end
    end
endmodule

// ===== dv/pic_host_model.sv
// Purpose: host processor model issuing port cycles and acknowledges
// Assumes: one strobe per access, signals change just after a clock edge
// Notes: released address lines show their inverse; write data is inverted only after a write
`timescale 1ns/1ps
module pic_host_model
    import pic_pkg::*;
(
    // clock
    input wire logic mclk,
    // host port
    output bus_req_s bus,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    // processor side
    output logic ack,
    input wire logic [7:0] vector,
    input wire logic vector_valid
);
    initial
    begin
        bus = '0;
        ack = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        bus = {3'b110, a, d};
        @(posedge mclk);
        #1;
        bus = {3'b000, ~a, ~d};
    endtask

    // a missing answer comes back as unknown so any compare fails
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        bus = {3'b101, a, bus.wdata};
        @(posedge mclk);
        #1;
        bus = {3'b000, ~a, bus.wdata};
        for (int i = 0; i < 3 && rdata_valid !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        d = (rdata_valid === 1'b1) ? rdata : 8'hxx;
    endtask

    task automatic acknowledge(output logic [7:0] v);
        @(posedge mclk);
        #1;
        ack = 1'b1;
        @(posedge mclk);
        #1;
        ack = 1'b0;
        for (int i = 0; i < 3 && vector_valid !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        v = (vector_valid === 1'b1) ? vector : 8'hxx;
    endtask

    task automatic init(input logic edge_mode, input logic auto_eos,
                        input logic [4:0] base);
        wr(PORT_LOWER, {4'h1, edge_mode, 3'h3});
        wr(PORT_UPPER, {base, 3'h0});
        wr(PORT_UPPER, {5'h00, 1'b1, auto_eos, 1'b1});
    endtask

    task automatic status(input logic [7:0] code, output logic [7:0] d);
        wr(PORT_LOWER, code);
        rd(PORT_LOWER, d);
    endtask
endmodule

// ===== dv/priority_interrupt_controller_tb_top.sv
// Purpose: self-checking bench for the priority interrupt controller
// Assumes: host model drives the port, bench drives the request pins
// Notes: intr is judged a fixed six cycles after the pin change or host access that precedes the check
`timescale 1ns/1ps
module priority_interrupt_controller_tb_top
    import pic_pkg::*;
();
    logic mclk;
    logic rst;
    bus_req_s bus;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [7:0] request_input;
    logic intr;
    logic ack;
    logic [7:0] vector;
    logic vector_valid;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    priority_interrupt_controller u_dut (
        .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
        .rdata_valid(rdata_valid), .request_input(request_input),
        .intr(intr), .ack(ack), .vector(vector),
        .vector_valid(vector_valid)
    );

    pic_host_model u_host (
        .mclk(mclk), .bus(bus), .rdata(rdata), .rdata_valid(rdata_valid),
        .ack(ack), .vector(vector), .vector_valid(vector_valid)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run needs about 300 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask

    // pins pass two sync stages plus the edge stage before intr moves
    task automatic chk_intr(input logic exp);
        repeat (6) @(posedge mclk);
        #1;
        samples_checked++;
        if (intr !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: intr %b", $time, intr);
        end
    endtask

    task automatic ackv(input logic [7:0] exp);
        logic [7:0] v;
        u_host.acknowledge(v);
        chk8(v, exp);
    endtask

    task automatic st(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        u_host.status(code, d);
        chk8(d, exp);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk8(d, exp);
    endtask

    task automatic t_init_mask();
        request_input[0] = 1'b1;
        u_host.wr(PORT_UPPER, 8'hff);
        u_host.wr(PORT_LOWER, 8'h13);
        u_host.wr(PORT_UPPER, 8'h08);
        chk_intr(1'b0);
        u_host.wr(PORT_UPPER, 8'h05);
        chk_intr(1'b1);
        ackv(8'h08);
        chk_intr(1'b0);
        request_input[0] = 1'b0;
        u_host.wr(PORT_LOWER, 8'h20);
        rdchk(PORT_UPPER, MASK_RESET);
        u_host.wr(PORT_UPPER, 8'ha5);
        rdchk(PORT_UPPER, 8'ha5);
        request_input[0] = 1'b1;
        chk_intr(1'b0);
        request_input[1] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h09);
        rdchk(8'hc4, 8'h00);
        $display("done init_mask");
    endtask

    task automatic t_nested();
        u_host.init(1'b0, 1'b0, 5'h01);
        request_input[3] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h0b);
        request_input[3] = 1'b0;
        request_input[5] = 1'b1;
        chk_intr(1'b0);
        st(8'h0a, 8'h20);
        request_input[1] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h09);
        request_input[1] = 1'b0;
        st(8'h0b, 8'h0a);
        u_host.wr(PORT_LOWER, 8'h20);
        st(8'h0b, 8'h08);
        chk_intr(1'b0);
        u_host.wr(PORT_LOWER, 8'h20);
        chk_intr(1'b1);
        ackv(8'h0d);
        $display("done nested");
    endtask

    task automatic t_auto_rotate();
        u_host.init(1'b0, 1'b0, 5'h01);
        request_input[4] = 1'b1;
        request_input[6] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h0c);
        request_input[4] = 1'b0;
        request_input[0] = 1'b1;
        u_host.wr(PORT_LOWER, 8'ha0);
        chk_intr(1'b1);
        ackv(8'h0e);
        st(8'h0b, 8'h40);
        $display("done auto_rotate");
    endtask

    task automatic t_specific();
        u_host.init(1'b0, 1'b0, 5'h01);
        u_host.wr(PORT_LOWER, 8'hc5);
        request_input[2] = 1'b1;
        request_input[6] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h0e);
        request_input[6] = 1'b0;
        chk_intr(1'b0);
        u_host.wr(PORT_LOWER, 8'he6);
        st(8'h0b, 8'h00);
        chk_intr(1'b1);
        ackv(8'h0a);
        st(8'h0b, 8'h04);
        $display("done specific");
    endtask

    task automatic t_special_mask();
        u_host.init(1'b0, 1'b0, 5'h01);
        request_input[2] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h0a);
        request_input[2] = 1'b0;
        u_host.wr(PORT_UPPER, 8'h04);
        request_input[4] = 1'b1;
        chk_intr(1'b0);
        u_host.wr(PORT_LOWER, 8'h68);
        chk_intr(1'b1);
        ackv(8'h0c);
        st(8'h0b, 8'h14);
        request_input[4] = 1'b0;
        u_host.wr(PORT_LOWER, 8'h64);
        st(8'h0b, 8'h04);
        // with the mode reset the masked level 2 must block level 4 again
        u_host.wr(PORT_LOWER, 8'h48);
        request_input[4] = 1'b1;
        chk_intr(1'b0);
        $display("done special_mask");
    endtask

    task automatic t_poll();
        u_host.init(1'b0, 1'b0, 5'h01);
        request_input[6] = 1'b1;
        request_input[7] = 1'b1;
        u_host.wr(PORT_LOWER, 8'h0c);
        rdchk(PORT_LOWER, 8'h86);
        st(8'h0b, 8'h40);
        $display("done poll");
    endtask

    task automatic t_edge_auto();
        u_host.init(1'b1, 1'b1, 5'h04);
        u_host.wr(PORT_LOWER, 8'h80);
        request_input[1] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h21);
        st(8'h0b, 8'h00);
        chk_intr(1'b0);
        request_input[1] = 1'b0;
        chk_intr(1'b0);
        request_input[1] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h21);
        // level 1 is now bottom, so level 2 outranks level 0
        request_input[0] = 1'b1;
        request_input[2] = 1'b1;
        chk_intr(1'b1);
        ackv(8'h22);
        $display("done edge_auto");
    endtask

    initial
    begin
        rst = 1'b1;
        request_input = 8'h00;
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_init_mask();
        request_input = 8'h00;
        t_nested();
        request_input = 8'h00;
        t_auto_rotate();
        request_input = 8'h00;
        t_specific();
        request_input = 8'h00;
        t_special_mask();
        request_input = 8'h00;
        t_poll();
        request_input = 8'h00;
        t_edge_auto();
        stop_test();
    end
endmodule
